// [shared/span_copy_params.svh]
`ifndef SPAN_COPY_PARAMS_SVH
`define SPAN_COPY_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_MODE 8'h00
`define OFS_ROTATE 8'h04
`define OFS_FETCH64 8'h08
`define OFS_STORE64 8'h0c
`define OFS_WIN_LO 8'h40
`define OFS_WIN_HI 8'h5c

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define MODE_COPY_BIT 0
`define MODE_BPP32_BIT 1
`define MODE_DIR_BIT 20
`define MODE_BUSY_BIT 21
`define FB_SPACE_BIT 31
`define MODE_RST 2'h0
`define ROTATE_RST 4'h0

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define QW_BYTES 8
`define BUF_ENTRIES 8
`define LAST_ENTRY 3'h7
`define LAST_ENTRY_8BPP 3'h3

`endif

// [shared/span_copy_pkg.sv]
`default_nettype none

package span_copy_pkg;

  typedef enum logic {DIR_FETCH, DIR_STORE} dir_t;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} eng_state_t;

  typedef logic [63:0] qword_t;

endpackage : span_copy_pkg

`default_nettype wire

// [src/byte_rotator.sv]
`default_nettype none

module byte_rotator
  import span_copy_pkg::*;
(
  input wire logic [63:0] rd_data,  // Quadword just read
  input wire logic [63:0] residue,  // Previous quadword read
  input wire logic [3:0] shift,     // Signed byte rotate amount
  output logic [63:0] aligned       // Quadword aligned to destination
);

  logic [127:0] cat;
  logic [127:0] rot;
  logic [7:0] sh_r;
  logic [7:0] sh_l;

  // A left rotate by n bytes equals a right rotate by 16 - n bytes, and
  // for a negative amount that is just the unsigned value of the field.
  always_comb begin
    cat = {rd_data, residue};
    sh_r = {1'b0, shift, 3'b000};
    sh_l = 8'h80 - sh_r;
    rot = (cat >> sh_r) | (cat << sh_l);
    aligned = rot[127:64];
  end

endmodule : byte_rotator

`default_nettype wire

// [src/span_copy_buffer_engine.sv]
// How it works
// - Each read: rotate data with residue (block fetch loads it unrotated), load buffer, save residue, step address.
// - Reading starts at first enabled quadword and ends after last one.
// - Two-state direction pointer at mode bit 20 picks fill or drain.
// - Writing rotate amount or copy buffer window sets pointer to fetch.
// - Every frame buffer write in copy mode toggles the pointer.
// - Copy buffer holds eight quadword entries, 0 through 7.
// - Fetch write fills up to 8 entries from entry 0; 8-bpp only 0-3.
// - Read enables choose loaded pixels; pixel-to-entry mapping never moves.
// - Full mask puts first pixel in entry 0 low byte, last in top.
// - Store write drains up to 8 entries from entry 0; 8-bpp only 0-3.
// - Write enables gate bytes or dwords; drain skips masked end quadwords.
// - Each entry always targets a fixed offset from the start address.
// - Pixel enable masks are 32 bits wide.
// - Block fetch register write fills exactly 8 entries, unmasked.
// - Block store register write drains exactly 8 entries, unmasked.
// - Rotate amount is signed 4-bit; negative copies backward.
// - 128-bit concatenation rotates; aligned quadword taken from read data slot.
// - Residue is a hidden 64-bit register holding the previous quadword.
`include "span_copy_params.svh"
`default_nettype none

module span_copy_buffer_engine
  import span_copy_pkg::*;
#(
  parameter int AW = 24  // Frame buffer byte address width
) (
  input wire logic core_clk,           // Core clock
  input wire logic rst,                // Asynchronous reset, active high
  input wire logic hsel,               // Slave select
  input wire logic [31:0] haddr,       // Bus address
  input wire logic [1:0] htrans,       // Transfer type
  input wire logic hwrite,             // Write when high
  input wire logic [2:0] hsize,        // Transfer size
  input wire logic hready,             // Bus ready in
  input wire logic [31:0] hwdata,      // Write data
  output logic [31:0] hrdata,          // Read data
  output logic hreadyout,              // Slave ready out
  output logic hresp,                  // Always OKAY
  output logic mem_req,                // Memory request, held until ack
  output logic mem_we,                 // Memory write when high
  output logic [AW-1:0] mem_addr,      // Quadword byte address
  output logic [63:0] mem_wdata,       // Memory write data
  output logic [7:0] mem_be,           // Byte enables
  input wire logic mem_ack,            // Memory accepted / read data valid
  input wire logic [63:0] mem_rdata    // Memory read data
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte enables of one quadword of the span; the mask bit position of a
  // pixel never depends on which other bits are set.
  function automatic logic [7:0] qw_be(input logic [31:0] m, input logic b32,
                                       input logic [2:0] i);
    logic [7:0] r;
    r = 8'h00;
    if (b32) begin
      r = {{4{m[{i, 1'b1}]}}, {4{m[{i, 1'b0}]}}};
    end else if (!i[2]) begin
      r = m[{i[1:0], 3'b000} +: 8];
    end
    return r;
  endfunction : qw_be

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic ap_valid_ff, nxt_ap_valid;
  logic ap_write_ff, nxt_ap_write;
  logic [31:0] ap_addr_ff, nxt_ap_addr;
  logic rd_done_ff, nxt_rd_done;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic eng_busy;
  logic wr_fire;
  logic [31:0] rd_value;
  logic [1:0] mode_ff, nxt_mode;
  logic [3:0] rotate_ff, nxt_rotate;
  dir_t dir_ff, nxt_dir;

  // Writes wait while the engine runs; reads take one extra cycle so
  // that hrdata comes from a flop holding the state after earlier writes.
  assign hreadyout = !(ap_valid_ff &&
                       ((ap_write_ff && eng_busy) || (!ap_write_ff && !rd_done_ff)));
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign wr_fire = ap_valid_ff && ap_write_ff && hreadyout;

  always_comb begin
    rd_value = 32'h0;
    if (ap_addr_ff[7:0] == `OFS_MODE && !ap_addr_ff[`FB_SPACE_BIT]) begin
      rd_value[`MODE_COPY_BIT] = mode_ff[0];
      rd_value[`MODE_BPP32_BIT] = mode_ff[1];
      rd_value[`MODE_DIR_BIT] = (dir_ff == DIR_STORE);
      rd_value[`MODE_BUSY_BIT] = eng_busy;
    end else if (ap_addr_ff[7:0] == `OFS_ROTATE && !ap_addr_ff[`FB_SPACE_BIT]) begin
      rd_value[3:0] = rotate_ff;
    end
  end

  always_comb begin
    nxt_ap_valid = ap_valid_ff;
    nxt_ap_write = ap_write_ff;
    nxt_ap_addr = ap_addr_ff;
    nxt_rd_done = 1'b0;
    nxt_hrdata = hrdata_ff;
    if (hreadyout) begin
      nxt_ap_valid = hsel && hready && htrans[1];
      nxt_ap_write = hwrite;
      nxt_ap_addr = haddr;
    end
    if (ap_valid_ff && !ap_write_ff && !rd_done_ff) begin
      nxt_rd_done = 1'b1;
      nxt_hrdata = rd_value;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff <= 32'h0;
      rd_done_ff <= 1'b0;
      hrdata_ff <= 32'h0;
    end else begin
      ap_valid_ff <= nxt_ap_valid;
      ap_write_ff <= nxt_ap_write;
      ap_addr_ff <= nxt_ap_addr;
      rd_done_ff <= nxt_rd_done;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ---------------------------------------------------------------
  // Control registers and direction pointer
  // ---------------------------------------------------------------
  logic fb_wr, reg_wr, rot_wr, win_wr, f64_wr, s64_wr;

  assign fb_wr = wr_fire && ap_addr_ff[`FB_SPACE_BIT] && mode_ff[0];
  assign reg_wr = wr_fire && !ap_addr_ff[`FB_SPACE_BIT];
  assign rot_wr = reg_wr && ap_addr_ff[7:0] == `OFS_ROTATE;
  assign win_wr = reg_wr && ap_addr_ff[7:0] >= `OFS_WIN_LO &&
                  ap_addr_ff[7:0] <= `OFS_WIN_HI;
  assign f64_wr = reg_wr && ap_addr_ff[7:0] == `OFS_FETCH64;
  assign s64_wr = reg_wr && ap_addr_ff[7:0] == `OFS_STORE64;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_rotate = rotate_ff;
    nxt_dir = dir_ff;
    if (reg_wr && ap_addr_ff[7:0] == `OFS_MODE) begin
      nxt_mode = {hwdata[`MODE_BPP32_BIT], hwdata[`MODE_COPY_BIT]};
    end
    if (rot_wr) begin
      nxt_rotate = hwdata[3:0];
    end
    if (rot_wr || win_wr) begin
      nxt_dir = DIR_FETCH;
    end else if (fb_wr) begin
      nxt_dir = (dir_ff == DIR_FETCH) ? DIR_STORE : DIR_FETCH;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= `MODE_RST;
      rotate_ff <= `ROTATE_RST;
      dir_ff <= DIR_FETCH;
    end else begin
      mode_ff <= nxt_mode;
      rotate_ff <= nxt_rotate;
      dir_ff <= nxt_dir;
    end
  end

  // ---------------------------------------------------------------
  // Span engine
  // ---------------------------------------------------------------
  eng_state_t state_ff, nxt_state;
  logic [2:0] idx_ff, nxt_idx;
  logic [2:0] last_ff, nxt_last;
  logic [AW-1:0] addr_ff, nxt_addr;
  logic [31:0] mask_ff, nxt_mask;
  logic full_ff, nxt_full;
  logic b32_ff, nxt_b32;
  logic back_ff, nxt_back;
  qword_t residue_ff, nxt_residue;
  qword_t copy_buf [`BUF_ENTRIES];
  qword_t aligned;
  logic start_fill, start_drain;
  logic [7:0] en;
  logic [2:0] first_i, last_i;
  logic any_en;
  logic [AW-1:0] base, first_off;
  logic [7:0] cur_be;
  logic buf_we;

  assign eng_busy = (state_ff != ST_IDLE);
  assign start_fill = (fb_wr && dir_ff == DIR_FETCH) || f64_wr;
  assign start_drain = (fb_wr && dir_ff == DIR_STORE) || s64_wr;
  assign cur_be = full_ff ? 8'hff : qw_be(mask_ff, b32_ff, idx_ff);

  byte_rotator u_rot (
    .rd_data(mem_rdata),
    .residue(residue_ff),
    .shift(rotate_ff),
    .aligned(aligned)
  );

  // Find the first and last quadwords with any pixel enabled.
  always_comb begin
    first_i = 3'h0;
    last_i = 3'h0;
    any_en = 1'b0;
    for (int i = 0; i < `BUF_ENTRIES; i++) begin
      en[i] = (f64_wr || s64_wr) ? 1'b1 : (qw_be(hwdata, mode_ff[1], 3'(i)) != 8'h00);
      if (en[i] && !any_en) begin
        first_i = 3'(i);
      end
      if (en[i]) begin
        last_i = 3'(i);
        any_en = 1'b1;
      end
    end
    base = (f64_wr || s64_wr) ? hwdata[AW-1:0] : ap_addr_ff[AW-1:0];
    base[2:0] = 3'h0;
    first_off = AW'({first_i, 3'b000});
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_last = last_ff;
    nxt_addr = addr_ff;
    nxt_mask = mask_ff;
    nxt_full = full_ff;
    nxt_b32 = b32_ff;
    nxt_back = back_ff;
    nxt_residue = residue_ff;
    buf_we = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if ((start_fill || start_drain) && any_en) begin
          nxt_state = start_fill ? ST_READ : ST_WRITE;
          nxt_idx = first_i;
          nxt_last = last_i;
          nxt_mask = hwdata;
          nxt_full = f64_wr || s64_wr;
          nxt_b32 = mode_ff[1];
          nxt_back = rotate_ff[3];
          nxt_addr = rotate_ff[3] ? base - first_off : base + first_off;
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          buf_we = 1'b1;
          nxt_residue = mem_rdata;
          nxt_addr = back_ff ? addr_ff - AW'(`QW_BYTES) : addr_ff + AW'(`QW_BYTES);
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff == last_ff) begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          nxt_addr = back_ff ? addr_ff - AW'(`QW_BYTES) : addr_ff + AW'(`QW_BYTES);
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff == last_ff) begin
            nxt_state = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      idx_ff <= 3'h0;
      last_ff <= 3'h0;
      addr_ff <= '0;
      mask_ff <= 32'h0;
      full_ff <= 1'b0;
      b32_ff <= 1'b0;
      back_ff <= 1'b0;
      residue_ff <= 64'h0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      last_ff <= nxt_last;
      addr_ff <= nxt_addr;
      mask_ff <= nxt_mask;
      full_ff <= nxt_full;
      b32_ff <= nxt_b32;
      back_ff <= nxt_back;
      residue_ff <= nxt_residue;
    end
  end

  // Only enabled bytes of an entry change, so masked pixels keep their
  // old contents and the entry of every pixel stays fixed.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `BUF_ENTRIES; i++) begin
        copy_buf[i] <= 64'h0;
      end
    end else if (buf_we) begin
      for (int b = 0; b < 8; b++) begin
        if (cur_be[b]) begin
          copy_buf[idx_ff][b*8 +: 8] <= full_ff ? mem_rdata[b*8 +: 8]
                                                : aligned[b*8 +: 8];
        end
      end
    end
  end

  assign mem_req = eng_busy;
  assign mem_we = (state_ff == ST_WRITE);
  assign mem_addr = addr_ff;
  assign mem_wdata = copy_buf[idx_ff];
  assign mem_be = cur_be;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  dir_fetch_rotate_a: assert property (rot_wr |=> dir_ff == DIR_FETCH)
    else $error("pointer not in fetch after rotate write");
  dir_toggle_a: assert property (fb_wr && !rot_wr && !win_wr |=> dir_ff != $past(dir_ff))
    else $error("pointer did not toggle on frame buffer write");
  fetch_fills_a: assert property (fb_wr && dir_ff == DIR_FETCH && any_en && !eng_busy
                                  |=> state_ff == ST_READ)
    else $error("fetch write did not start a fill");
  store_drains_a: assert property (fb_wr && dir_ff == DIR_STORE && any_en && !eng_busy
                                   |=> state_ff == ST_WRITE)
    else $error("store write did not start a drain");
  residue_load_a: assert property (state_ff == ST_READ && mem_ack
                                   |=> residue_ff == $past(mem_rdata))
    else $error("residue not loaded from read data");
  read_step_a: assert property (state_ff == ST_READ && mem_ack && idx_ff != last_ff
                                |=> mem_addr == ($past(back_ff) ? $past(mem_addr) - AW'(8)
                                                 : $past(mem_addr) + AW'(8)))
    else $error("read address did not step by one quadword");
  block64_len_a: assert property (f64_wr && !eng_busy
                                  |=> idx_ff == 3'h0 && last_ff == `LAST_ENTRY && full_ff)
    else $error("block fetch does not cover eight entries");
  narrow_entries_a: assert property (eng_busy && !full_ff && !b32_ff
                                     |-> idx_ff <= `LAST_ENTRY_8BPP)
    else $error("8-bpp span reached past entry 3");
  drain_mask_a: assert property (state_ff == ST_WRITE && !full_ff && !b32_ff
                                 |-> mem_be == mask_ff[{idx_ff[1:0], 3'b000} +: 8])
    else $error("drain byte enables do not follow mask");

  fill_seen_c: cover property (state_ff == ST_READ && mem_ack && idx_ff == last_ff);
  drain_seen_c: cover property (state_ff == ST_WRITE && mem_ack && idx_ff == last_ff);
  back_copy_c: cover property (state_ff == ST_READ && back_ff && mem_ack);

endmodule : span_copy_buffer_engine

`default_nettype wire

// [bench/fb_mem_model.sv]
`default_nettype none

module fb_mem_model
  import span_copy_pkg::*;
#(
  parameter int AW = 24
) (
  input wire logic core_clk,          // Core clock
  input wire logic rst,               // Reset, active high
  input wire logic slow,              // Random wait states when high
  input wire logic mem_req,           // Access request
  input wire logic mem_we,            // Write when high
  input wire logic [AW-1:0] mem_addr, // Quadword byte address
  input wire logic [63:0] mem_wdata,  // Write data
  input wire logic [7:0] mem_be,      // Byte enables
  output logic mem_ack,               // Accept pulse
  output logic [63:0] mem_rdata       // Read data, valid with ack
);
  timeunit 1ns;
  timeprecision 1ps;

  qword_t mem [logic [AW-1:0]];
  qword_t q;
  int nrd = 0;
  int nwr = 0;
  int wt;
  int seed = 25749;

  function automatic qword_t peek(input logic [AW-1:0] a);
    return mem.exists(a) ? mem[a] : {~{8'h5a, a[23:0]}, 8'h5a, a[23:0]};
  endfunction : peek

  // Read data is inverted every idle cycle so a late sample never looks valid.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 64'h0;
      wt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_ack) begin
        q = peek(mem_addr);
        for (int k = 0; k < 8; k++) begin
          if (mem_be[k]) begin
            q[8*k+:8] = mem_wdata[8*k+:8];
          end
        end
        if (mem_we) begin
          mem[mem_addr] = q;
          nwr++;
        end else begin
          nrd++;
        end
        wt <= slow ? int'($unsigned($random(seed)) % 4) : 0;
      end else if (mem_req && wt != 0) begin
        wt <= wt - 1;
      end else if (mem_req) begin
        mem_ack <= 1'b1;
        mem_rdata <= peek(mem_addr);
      end
    end
  end
endmodule : fb_mem_model

`default_nettype wire

// [bench/span_copy_buffer_engine_tb.sv]
`default_nettype none

module span_copy_buffer_engine_tb
  import span_copy_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic mem_req;
  logic mem_we;
  logic [23:0] mem_addr;
  logic [63:0] mem_wdata;
  logic [7:0] mem_be;
  logic mem_ack;
  logic [63:0] mem_rdata;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 25749;
  logic b32 = 1'b0;
  logic [3:0] rot = 4'h0;
  logic dir = 1'b0;
  qword_t ebuf [8];
  qword_t eres;
  qword_t emem [logic [23:0]];

  span_copy_buffer_engine u_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  fb_mem_model u_mem (.core_clk(core_clk), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Ready is looked at on the falling edge, where it has settled for this cycle.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rdm(input logic [31:0] a, input logic [31:0] msk, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check({31'h0, hresp, r & msk}, {32'h0, e});
  endtask : rdm

  function automatic logic [7:0] be_of(input logic [31:0] m, input int i);
    return b32 ? {{4{m[2*i+1]}}, {4{m[2*i]}}} : m[8*i+:8];
  endfunction : be_of

  task automatic op(input logic fill, input logic blk, input logic [23:0] base,
                    input logic [31:0] m);
    int first;
    int last;
    int nr0;
    int nw0;
    logic [23:0] a;
    logic [7:0] be;
    qword_t q;
    logic [255:0] w;
    first = -1;
    last = -1;
    for (int i = 0; i < ((blk || b32) ? 8 : 4); i++) begin
      if (blk || be_of(m, i) != 8'h0) begin
        if (first < 0) begin
          first = i;
        end
        last = i;
      end
    end
    nr0 = u_mem.nrd;
    nw0 = u_mem.nwr;
    if (blk) begin
      wr(fill ? 32'h8 : 32'hc, {8'h0, base});
    end else begin
      wr({1'b1, 7'h0, base}, m);
      dir = ~dir;
    end
    // A write stalls while the engine is busy, so this one marks completion.
    wr(32'h80, 32'h0);
    for (int i = first; i <= last && first >= 0; i++) begin
      a = base + 24'((rot[3] ? -8 : 8) * i);
      be = blk ? 8'hff : be_of(m, i);
      q = emem.exists(a) ? emem[a] : u_mem.peek(a);
      w = {q, eres, q, eres};
      for (int k = 0; k < 8; k++) begin
        if (fill && be[k]) begin
          ebuf[i][8*k+:8] = blk ? q[8*k+:8] : w[8*rot+64+8*k+:8];
        end else if (be[k]) begin
          q[8*k+:8] = ebuf[i][8*k+:8];
        end
      end
      if (fill) begin
        eres = q;
      end else begin
        emem[a] = q;
      end
    end
    check(64'(u_mem.nrd - nr0), 64'(fill && first >= 0 ? last - first + 1 : 0));
    check(64'(u_mem.nwr - nw0), 64'(!fill && first >= 0 ? last - first + 1 : 0));
    foreach (emem[x]) begin
      check(u_mem.peek(x), emem[x]);
    end
    rdm(32'h0, 32'h0010_0000, {11'h0, dir, 20'h0});
  endtask : op

  initial begin
    logic [31:0] cm [4];
    logic [3:0] cr [4];
    logic [31:0] m1;
    int n;
    cm = '{32'h00ffff00, 32'hffffffff, 32'h80000001, 32'h0};
    cr = '{4'h0, 4'h7, 4'h8, 4'hf};
    eres = '0;
    foreach (ebuf[i]) begin
      ebuf[i] = '0;
    end
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rdm(32'h0, 32'hffffffff, 32'h0);
    rdm(32'h4, 32'hffffffff, 32'h0);
    wr(32'h0, 32'h1);
    op(1'b1, 1'b1, 24'h010000, 32'h0);
    op(1'b0, 1'b1, 24'h020000, 32'h0);
    op(1'b1, 1'b0, 24'h030000, 32'h0);
    wr(32'h48, 32'h0);
    dir = 1'b0;
    rdm(32'h0, 32'h0010_0000, 32'h0);
    for (int it = 0; it < 24; it++) begin
      b32 = (it < 4) ? it[0] : 1'($random(seed));
      rot = (it < 4) ? cr[it] : 4'($random(seed));
      m1 = (it < 4) ? cm[it] : $random(seed);
      slow <= 1'($random(seed));
      wr(32'h0, {30'h0, b32, 1'b1});
      wr(32'h4, {28'h0, rot});
      rdm(32'h4, 32'h0000000f, {28'h0, rot});
      dir = 1'b0;
      rdm(32'h0, 32'h0010_0000, 32'h0);
      op(1'b1, 1'b0, 24'h100000 | (24'($random(seed)) & 24'h00fff8), m1);
      op(1'b0, 1'b0, 24'h200000 | (24'($random(seed)) & 24'h00fff8),
         (it < 3) ? 32'hffffffff : $random(seed));
    end
    wr(32'h0, 32'h0);
    n = u_mem.nrd + u_mem.nwr;
    wr(32'h80300000, 32'hffffffff);
    wr(32'h80, 32'h0);
    check(64'(u_mem.nrd + u_mem.nwr), 64'(n));
    rdm(32'h0, 32'h0010_0000, {11'h0, dir, 20'h0});
    summarize();
  end
endmodule : span_copy_buffer_engine_tb

`default_nettype wire
